// >>> hdl/modem_ctrl_pkg.sv
// Constants shared by the modem control port and its helpers.
// Assumes a 10 MHz core clock stands in for the modem timing reference.
package modem_ctrl_pkg;
  // ==========================================================
  // Register map
  localparam logic [1:0] REG_MAIN = 2'h0;
  localparam logic [1:0] REG_AUX = 2'h1;
  localparam logic [1:0] REG_DETECT = 2'h2;
  localparam logic [1:0] REG_TONE = 2'h3;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  // ==========================================================
  // Field positions
  localparam int MAIN_LOW_SPEED = 5;
  localparam int MAIN_MODE_LSB = 2;
  localparam int MAIN_TX_EN = 1;
  localparam int MAIN_ORG = 0;
  localparam int AUX_INT_EN = 5;
  localparam int AUX_CLK_SEL = 3;
  localparam int AUX_SOFT_RST = 2;
  localparam int TONE_RXD_OPEN = 7;
  localparam int TONE_ANS = 5;
  localparam int TONE_TONE_AND_DATA_SELECT = 4;
  localparam int DET_WATCHED = 5;
  // ==========================================================
  // Transmit mode field
  localparam logic [2:0] MODE_PWR_DOWN = 3'h0;
  localparam logic [2:0] MODE_SYNC_INT = 3'h1;
  localparam logic [2:0] MODE_SYNC_EXT = 3'h2;
  localparam logic [2:0] MODE_SYNC_SLAVE = 3'h3;
  localparam int MODE_ASYNC_BIT = 2;
  // ==========================================================
  // Timing
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int XTAL_HZ = 11_059_200;
  localparam int BIT_RATE_HZ = 1200;
  localparam int BAUD_MULT = 16;
  localparam int XTAL_HALF_CYC = 1;
  localparam int BAUD_HALF_CYC = CORE_CLK_HZ / (2 * BAUD_MULT * BIT_RATE_HZ);
  localparam int BIT_HALF_CYC = CORE_CLK_HZ / (2 * BIT_RATE_HZ);
endpackage

// >>> hdl/bit_clock_divider.sv
// Square wave divider with registered edge pulses.
// Assumes run and restart come from logic on core_clk.
`timescale 1ns/10ps
module bit_clock_divider
  import modem_ctrl_pkg::*;
#(
  parameter int HALF = 4
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic restart,
  output logic clk_level,
  output logic rise,
  output logic fall
);
  localparam int CW = $clog2(HALF + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lvl;
    logic rise;
    logic fall;
  } div_state_t;
  div_state_t s, n;

  always_comb
  begin
    n = s;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (!run)
    begin
      n.cnt = '0;
      n.lvl = 1'b0;
      n.fall = s.lvl;
    end
    else if (restart)
    begin
      // Phase pull: restart forces the level high now, a rising edge only if it was low
      n.cnt = '0;
      n.lvl = 1'b1;
      n.rise = ~s.lvl;
    end
    else if (s.cnt == CW'(HALF - 1))
    begin
      n.cnt = '0;
      n.lvl = ~s.lvl;
      n.rise = ~s.lvl;
      n.fall = s.lvl;
    end
    else
      n.cnt = s.cnt + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  assign clk_level = s.lvl;
  assign rise = s.rise;
  assign fall = s.fall;
endmodule

// >>> hdl/two_entry_buffer.sv
// Two-entry valid/ready buffer; flags are registered.
// Assumes both sides run on core_clk.
`timescale 1ns/10ps
module two_entry_buffer
#(
  parameter int WIDTH = 1
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] count;
    logic wp;
    logic rp;
    logic rdy;
    logic vld;
  } buf_state_t;
  buf_state_t s, n;
  logic push;
  logic pop;

  always_comb
  begin
    n = s;
    push = in_valid & s.rdy;
    pop = out_ready & s.vld;
    if (push)
    begin
      n.mem[s.wp] = in_data;
      n.wp = ~s.wp;
    end
    if (pop)
      n.rp = ~s.rp;
    n.count = s.count + {1'b0, push} - {1'b0, pop};
    // Registered flags: full stalls the source, empty stalls the drain
    n.rdy = (n.count != 2'h2);
    n.vld = (n.count != 2'h0);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.rdy <= 1'b1;
    end
    else
      s <= n;
  end

  assign in_ready = s.rdy;
  assign out_valid = s.vld;
  assign out_data = s.mem[s.rp];
endmodule

// >>> hdl/modem_host_control_port.sv
// Host control port of a 1200 bps modem (low-speed bit stored only): registers, parallel and
// serial command ports, interrupt, clock output and bit clocks.
// Assumes pins are asynchronous to core_clk; modem core signals are not.
`timescale 1ns/10ps
module modem_host_control_port
  import modem_ctrl_pkg::*;
#(
  parameter int BIT_HALF = BIT_HALF_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reset_pin,
  input wire logic addr_latch,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] muxed_addr_data_bus_in,
  output logic [7:0] muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe,
  input wire logic [1:0] reg_select_lines,
  input wire logic ser_read_n,
  input wire logic ser_write_n,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe,
  input wire logic ext_timing_ref,
  input wire logic xmit_data_in,
  output logic clock_out,
  output logic int_n,
  output logic recv_bit_clock,
  output logic recv_data,
  output logic recv_data_oe,
  output logic xmit_bit_clock,
  output logic xmit_bit,
  output logic xmit_bit_strobe,
  input wire logic demod_bit_valid,
  input wire logic demod_bit,
  output logic demod_bit_ready,
  input wire logic long_loop,
  input wire logic call_progress,
  input wire logic answer_tone,
  input wire logic carrier_sense,
  input wire logic remote_loop_request,
  output logic [7:0] main_control,
  output logic [7:0] aux_control,
  output logic [7:0] tone_and_data_select,
  output logic tone_and_data_select_start
);
  // ==========================================================
  // State
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] ad;
    logic srd_n;
    logic swr_n;
    logic sdin;
    logic ext;
    logic txd;
    logic rst;
    logic [1:0] sel;
  } pin_t;
  localparam pin_t PIN_IDLE = '{ale: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00,
    srd_n: 1'b1, swr_n: 1'b1, sdin: 1'b0, ext: 1'b0, txd: 1'b1, rst: 1'b0, sel: 2'h0};
  typedef struct packed {
    pin_t m;
    pin_t p;
    pin_t q;
    logic [7:0] main_r;
    logic [7:0] aux_r;
    logic [7:0] det_r;
    logic [7:0] tone_r;
    logic [1:0] addr;
    logic cs_lat;
    logic [7:0] wr_hold;
    logic [7:0] shift;
    logic int_pend;
    logic int_n;
    logic [7:0] ad_out;
    logic ad_oe;
    logic sdout;
    logic sdoe;
    logic xtal_tgl;
    logic clk_out;
    logic rxd;
    logic rxd_oe;
    logic tx_bit;
    logic tx_stb;
    logic tone_and_data_select_go;
  } main_state_t;
  main_state_t s, n;

  logic baud_lvl;
  logic rclk_lvl;
  logic rclk_rise;
  logic rclk_fall;
  logic xclk_lvl;
  logic xclk_rise;
  logic xclk_restart;
  logic buf_valid;
  logic buf_data;
  logic [2:0] tx_mode;
  logic ale_fall, wr_rise, rd_fall, srd_fall, swr_rise, ext_fall, ext_rise;
  logic we, det_rd;
  logic [1:0] waddr;
  logic [7:0] wdata;
  logic [5:0] det_now;

  function automatic logic [7:0] read_mux(input logic [1:0] a, input main_state_t st);
    case (a)
      REG_MAIN: read_mux = st.main_r;
      REG_AUX: read_mux = st.aux_r;
      REG_DETECT: read_mux = st.det_r;
      default: read_mux = st.tone_r;
    endcase
  endfunction

  // ==========================================================
  // Clock sources
  bit_clock_divider #(.HALF(BAUD_HALF_CYC)) baud_div (
    .core_clk(core_clk), .reset_n(reset_n), .run(1'b1), .restart(1'b0),
    .clk_level(baud_lvl), .rise(), .fall());
  // Receive clock only runs while carrier is present
  bit_clock_divider #(.HALF(BIT_HALF)) recv_div (
    .core_clk(core_clk), .reset_n(reset_n), .run(carrier_sense), .restart(1'b0),
    .clk_level(rclk_lvl), .rise(rclk_rise), .fall(rclk_fall));
  bit_clock_divider #(.HALF(BIT_HALF)) xmit_div (
    .core_clk(core_clk), .reset_n(reset_n), .run(1'b1), .restart(xclk_restart),
    .clk_level(xclk_lvl), .rise(xclk_rise), .fall());
  // Demodulated bits wait here until the next receive clock fall
  two_entry_buffer #(.WIDTH(1)) rx_buf (
    .core_clk(core_clk), .reset_n(reset_n), .in_valid(demod_bit_valid), .in_data(demod_bit),
    .in_ready(demod_bit_ready), .out_valid(buf_valid), .out_data(buf_data),
    .out_ready(rclk_fall));

  assign tx_mode = s.main_r[MAIN_MODE_LSB+2:MAIN_MODE_LSB];
  // External mode pulls phase to the reference edge, slave to the receive clock
  assign xclk_restart = (tx_mode == MODE_SYNC_EXT && ext_rise) ||
    (tx_mode == MODE_SYNC_SLAVE && rclk_rise);

  // ==========================================================
  // Edge detection on synchronised pins
  assign ale_fall = s.q.ale & ~s.p.ale;
  assign wr_rise = ~s.q.wr_n & s.p.wr_n;
  assign rd_fall = s.q.rd_n & ~s.p.rd_n;
  assign srd_fall = s.q.srd_n & ~s.p.srd_n;
  assign swr_rise = ~s.q.swr_n & s.p.swr_n;
  assign ext_fall = s.q.ext & ~s.p.ext;
  assign ext_rise = ~s.q.ext & s.p.ext;
  assign det_now = {s.rxd, remote_loop_request, carrier_sense, answer_tone, call_progress,
    long_loop};

  // ==========================================================
  // Next state
  always_comb
  begin
    n = s;
    n.m = '{ale: addr_latch, cs_n: chip_sel_n, rd_n: read_n, wr_n: write_n,
      ad: muxed_addr_data_bus_in, srd_n: ser_read_n, swr_n: ser_write_n, sdin: ser_data_in,
      ext: ext_timing_ref, txd: xmit_data_in, rst: reset_pin, sel: reg_select_lines};
    n.p = s.m;
    n.q = s.p;
    we = 1'b0;
    waddr = 2'h0;
    wdata = 8'h00;
    if (ale_fall)
    begin
      n.addr = s.p.ad[1:0];
      n.cs_lat = ~s.p.cs_n;
    end
    // Data is held while the strobe is low, so its short hold time is safe
    if (!s.p.wr_n)
      n.wr_hold = s.p.ad;
    if (wr_rise && s.cs_lat && !s.p.cs_n)
    begin
      we = 1'b1;
      waddr = s.addr;
      wdata = s.wr_hold;
    end
    n.ad_oe = s.cs_lat & ~s.p.cs_n & ~s.p.rd_n;
    n.ad_out = n.ad_oe ? read_mux(s.addr, s) : 8'h00;
    // Serial port; select lines are trusted steady for the whole access
    n.sdoe = ~s.p.srd_n;
    if (srd_fall)
      n.shift = read_mux(s.p.sel, s);
    else if (ext_fall)
      n.shift = {s.p.srd_n ? s.p.sdin : 1'b0, s.shift[7:1]};
    n.sdout = n.sdoe & n.shift[0];
    // A serial store wins over a parallel one in the same cycle
    if (swr_rise)
    begin
      we = 1'b1;
      waddr = s.p.sel;
      wdata = s.shift;
    end
    if (we)
    begin
      case (waddr)
        REG_MAIN: n.main_r = {2'b00, wdata[5:0]};
        REG_AUX: n.aux_r = wdata;
        REG_TONE: n.tone_r = {wdata[7], 1'b0, wdata[5:0]};
        default: n.det_r = s.det_r;
      endcase
    end
    n.tone_and_data_select_go = s.main_r[MAIN_TX_EN] & ~n.main_r[MAIN_TX_EN] & n.tone_r[TONE_TONE_AND_DATA_SELECT];
    // Detect status: a change in the five watched bits raises the flag, and a new change beats the clearing read
    det_rd = (rd_fall && s.cs_lat && !s.p.cs_n && s.addr == REG_DETECT) ||
      (srd_fall && s.p.sel == REG_DETECT);
    n.det_r = {2'b00, det_now};
    n.int_pend = (det_now[DET_WATCHED-1:0] != s.det_r[DET_WATCHED-1:0]) |
      (s.int_pend & ~det_rd);
    if (s.p.rst || s.aux_r[AUX_SOFT_RST])
    begin
      n.main_r = REG_RESET_VAL;
      n.aux_r = REG_RESET_VAL;
      n.tone_r = REG_RESET_VAL;
      n.int_pend = 1'b0;
      n.tone_and_data_select_go = 1'b0;
    end
    n.int_n = ~(n.int_pend & n.aux_r[AUX_INT_EN]);
    n.xtal_tgl = ~s.xtal_tgl;
    n.clk_out = s.aux_r[AUX_CLK_SEL] ? baud_lvl : s.xtal_tgl;
    if (rclk_fall && buf_valid)
      n.rxd = buf_data;
    n.rxd_oe = ~s.tone_r[TONE_RXD_OPEN];
    // Terminal data is taken at the transmit clock rise
    if (xclk_rise)
      n.tx_bit = s.p.txd;
    n.tx_stb = xclk_rise;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.m <= PIN_IDLE;
      s.p <= PIN_IDLE;
      s.q <= PIN_IDLE;
      s.int_n <= 1'b1;
      s.rxd_oe <= 1'b1;
    end
    else
      s <= n;
  end

  // ==========================================================
  // Outputs
  assign muxed_addr_data_bus_out = s.ad_out;
  assign muxed_addr_data_bus_oe = s.ad_oe;
  assign ser_data_out = s.sdout;
  assign ser_data_oe = s.sdoe;
  assign clock_out = s.clk_out;
  assign int_n = s.int_n;
  assign recv_bit_clock = rclk_lvl;
  assign recv_data = s.rxd;
  assign recv_data_oe = s.rxd_oe;
  assign xmit_bit_clock = xclk_lvl;
  assign xmit_bit = s.tx_bit;
  assign xmit_bit_strobe = s.tx_stb;
  assign main_control = s.main_r;
  assign aux_control = s.aux_r;
  assign tone_and_data_select = s.tone_r;
  assign tone_and_data_select_start = s.tone_and_data_select_go;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  addr_latch_a: assert property (ale_fall |=> s.addr == $past(s.p.ad[1:0]))
    else $error("address not captured at latch fall");
  bus_float_a: assert property (s.ad_oe |-> $past(!s.p.cs_n && s.cs_lat))
    else $error("bus driven without chip select");
  // The first cycles after reset release still see reset values through $past
  crystal_clock_a: assert property ($past(reset_n, 2) && !s.aux_r[AUX_CLK_SEL] && $past(!s.aux_r[AUX_CLK_SEL], 2)
    |-> s.clk_out != $past(s.clk_out))
    else $error("crystal clock output not toggling");
  int_clear_a: assert property (det_rd && !s.p.rst ##1 $stable(s.det_r[4:0]) |-> s.int_n)
    else $error("interrupt not released by detect read");
  read_data_a: assert property (n.ad_oe |=> s.ad_out == $past(read_mux(s.addr, s)))
    else $error("wrong register on bus");
  pin_reset_a: assert property (s.p.rst |=> s.main_r == 8'h00 && s.aux_r == 8'h00
    && s.tone_r == 8'h00 ##2 !s.aux_r[AUX_CLK_SEL] || s.p.rst == 1'b0)
    else $error("reset pin did not clear registers");
  par_write_a: assert property (wr_rise && s.cs_lat && !s.p.cs_n && !swr_rise && !s.p.rst
    && !s.aux_r[AUX_SOFT_RST] && s.addr == REG_AUX |=> s.aux_r == $past(s.wr_hold))
    else $error("parallel write lost");
  ext_lock_a: assert property (tx_mode == MODE_SYNC_EXT && ext_rise |=> ##[0:1] xclk_lvl)
    else $error("transmit clock not locked to reference");
  recv_off_a: assert property (!carrier_sense [*3] |-> !rclk_lvl)
    else $error("receive clock runs without carrier");
  ser_shift_a: assert property (ext_fall && !s.p.srd_n && !srd_fall |=> s.sdout == $past(s.shift[1]))
    else $error("serial read order wrong");
  ser_store_a: assert property (swr_rise && s.p.sel == REG_TONE && !s.p.rst && !s.aux_r[AUX_SOFT_RST]
    |=> s.tone_r == {$past(s.shift[7]), 1'b0, $past(s.shift[5:0])})
    else $error("serial write not stored");
  int_mask_a: assert property (!s.aux_r[AUX_INT_EN] |-> s.int_n)
    else $error("masked interrupt asserted");
  det_raise_a: assert property (s.aux_r[AUX_INT_EN] && !s.aux_r[AUX_SOFT_RST] && !s.p.rst && !we
    && det_now[3] != s.det_r[3] |=> !s.int_n)
    else $error("carrier change did not interrupt");

  par_read_c: cover property (rd_fall && s.cs_lat ##[1:20] s.ad_oe);
  ser_write_c: cover property (swr_rise && s.p.sel == REG_MAIN);
  dial_c: cover property (s.tone_and_data_select_go);
  rx_bit_c: cover property (rclk_fall && buf_valid);
endmodule

// >>> tb/host_serial_model.sv
// Serial command host and terminal data source for the modem control port.
// Assumes a 100 ns core clock; the shift clock stands low outside frames.
`timescale 1ns/10ps
module host_serial_model
(
  input wire logic core_clk,
  input wire logic ser_data_out,
  input wire logic ser_data_oe,
  input wire logic xmit_bit_clock,
  output logic ext_timing_ref,
  output logic ser_read_n,
  output logic ser_write_n,
  output logic ser_data_in,
  output logic [1:0] reg_select_lines,
  output logic xmit_data_in
);
  initial
  begin
    ext_timing_ref = 1'h0;
    ser_read_n = 1'h1;
    ser_write_n = 1'h1;
    ser_data_in = 1'h0;
    reg_select_lines = 2'h0;
    xmit_data_in = 1'h0;
  end
  // ==========
  // Terminal: new bit on the fall so it is steady at the rise
  always @(negedge xmit_bit_clock)
    xmit_data_in <= ~xmit_data_in;
  // ==========
  // Serial frames, 800 ns shift clock
  task automatic ser_write(input logic [1:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    #5;
    reg_select_lines = addr;
    for (int i = 0; i < 8; i++)
    begin
      ser_data_in = data[i];
      ext_timing_ref = 1'h1;
      #400;
      ext_timing_ref = 1'h0;
      #400;
    end
    ser_write_n = 1'h0;
    #400;
    ser_write_n = 1'h1;
    #400;
    ser_data_in = ~data[7];
  endtask
  task automatic ser_read(input logic [1:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    #5;
    reg_select_lines = addr;
    // Select settles before the strobe, both pass the same synchronisers
    #100;
    ser_read_n = 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      ser_data_in = ~ser_data_in;
      #400;
      ext_timing_ref = 1'h1;
      #400;
      data[i] = ser_data_oe ? ser_data_out : 1'hx;
      ext_timing_ref = 1'h0;
    end
    #400;
    ser_read_n = 1'h1;
    #400;
  endtask
endmodule

// >>> tb/test_modem_host_control_port.sv
// Self-checking bench for the modem host control port.
// Assumes the serial host model owns the shift clock and terminal data.
`timescale 1ns/10ps
module test_modem_host_control_port;
  import modem_ctrl_pkg::*;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic reset_pin = 1'h0;
  logic addr_latch = 1'h0;
  logic chip_sel_n = 1'h1;
  logic sel_n = 1'h0;
  logic read_n = 1'h1;
  logic write_n = 1'h1;
  logic [7:0] host_bus = 8'h00;
  logic demod_bit_valid = 1'h0;
  logic demod_bit = 1'h0;
  logic [4:0] cond = 5'h00;
  logic [7:0] muxed_addr_data_bus_out, main_control, aux_control, tone_and_data_select;
  logic muxed_addr_data_bus_oe, ser_data_out, ser_data_oe, clock_out, int_n, recv_bit_clock;
  logic recv_data, recv_data_oe, xmit_bit_clock, demod_bit_ready, tone_and_data_select_start, last_oe;
  logic ext_timing_ref, ser_read_n, ser_write_n, host_ser, xmit_data_in, xmit_bit, xmit_bit_strobe;
  logic [1:0] reg_select_lines;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int tone_and_data_select_seen = 0;
  int model [4] = '{0, 0, 0, 0};
  int keep [4] = '{8'h3F, 8'hFF, 8'h00, 8'hBF};
  int q [$];
  // Small bit half period keeps the receive path scenario short
  modem_host_control_port #(.BIT_HALF(20)) i_modem_host_control_port
  (
    .core_clk, .reset_n, .reset_pin, .addr_latch, .chip_sel_n, .read_n, .write_n,
    .muxed_addr_data_bus_in(muxed_addr_data_bus_oe ? muxed_addr_data_bus_out : host_bus),
    .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .reg_select_lines, .ser_read_n, .ser_write_n,
    .ser_data_in(ser_data_oe ? ser_data_out : host_ser), .ser_data_out, .ser_data_oe,
    .ext_timing_ref, .xmit_data_in, .clock_out, .int_n, .recv_bit_clock, .recv_data, .recv_data_oe,
    .xmit_bit_clock, .xmit_bit, .xmit_bit_strobe, .demod_bit_valid, .demod_bit, .demod_bit_ready,
    .long_loop(cond[0]), .call_progress(cond[1]), .answer_tone(cond[2]), .carrier_sense(cond[3]),
    .remote_loop_request(cond[4]), .main_control, .aux_control, .tone_and_data_select, .tone_and_data_select_start
  );
  host_serial_model i_host_serial_model
  (
    .core_clk, .ser_data_out, .ser_data_oe, .xmit_bit_clock, .ext_timing_ref, .ser_read_n,
    .ser_write_n, .ser_data_in(host_ser), .reg_select_lines, .xmit_data_in
  );
  always #50 core_clk = ~core_clk;
  // ==========
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic void model_set(input int a, input int d);
    if (a != 2)
      model[a] = d & keep[a];
  endfunction
  task automatic par_start(input logic [1:0] addr);
    host_bus = {6'h00, addr};
    chip_sel_n = sel_n;
    addr_latch = 1'h1;
    tick(3);
    addr_latch = 1'h0;
    tick(4);
  endtask
  task automatic par_write(input logic [1:0] addr, input logic [7:0] data);
    par_start(addr);
    host_bus = data;
    write_n = 1'h0;
    tick(4);
    write_n = 1'h1;
    tick(4);
    chip_sel_n = 1'h1;
    host_bus = ~data;
    tick(4);
    if (!sel_n)
      model_set(addr, data);
  endtask
  task automatic par_read(input logic [1:0] addr, output logic [7:0] data);
    par_start(addr);
    host_bus = 8'($urandom);
    read_n = 1'h0;
    for (int w = 0; w < 8 && muxed_addr_data_bus_oe !== 1'h1; w++)
      tick(1);
    last_oe = muxed_addr_data_bus_oe;
    data = muxed_addr_data_bus_out;
    read_n = 1'h1;
    chip_sel_n = 1'h1;
    tick(4);
  endtask
  task automatic half_period(output int n);
    logic v;
    // First pass only finds an edge; the second counts a whole half
    for (int k = 0; k < 2; k++)
    begin
      v = clock_out;
      n = 0;
      while (clock_out === v && n < 600)
      begin
        tick(1);
        n++;
      end
    end
  endtask
  task automatic wait_level(input logic v);
    for (int w = 0; w < 200 && recv_bit_clock !== v; w++)
      tick(1);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (tone_and_data_select_start === 1'h1)
      tone_and_data_select_seen++;
    if (cycles == 40000)
    begin
      num_errors++;
      complete_run();
    end
  end
  // ==========
  // Scenarios
  initial
  begin
    int d;
    logic [7:0] rd;
    void'($urandom(87));
    tick(10);
    reset_n = 1'h1;
    tick(2);
    for (int i = 0; i < 4; i++)
    begin
      par_read(2'(i), rd);
      check(16'(rd & 8'hDF), 16'h0000);
    end
    // Soft reset and interrupt enable kept clear in random aux values
    for (int i = 0; i < 12; i++)
    begin
      d = $urandom & ((i % 4 == 1) ? 8'hDB : 8'hFF);
      par_write(2'(i % 4), 8'(d));
      par_read(2'(i % 4), rd);
      check(16'(rd & ((i % 4 == 2) ? 8'hDF : 8'hFF)), 16'(model[i % 4]));
    end
    check(16'(aux_control), 16'(model[1]));
    check(16'(tone_and_data_select), 16'(model[3]));
    check(16'(recv_data_oe), 16'(model[3] < 128));
    for (int m = 0; m < 8; m++)
    begin
      par_write(REG_MAIN, 8'(m * 4 + 8'hC1));
      check(16'(main_control), 16'(model[0]));
    end
    sel_n = 1'h1;
    par_write(REG_MAIN, 8'h00);
    par_read(REG_MAIN, rd);
    sel_n = 1'h0;
    check(16'(last_oe), 16'h0000);
    check(16'(main_control), 16'(model[0]));
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom & 8'hDB;
      i_host_serial_model.ser_write(2'(i), 8'(d));
      model_set(i, d);
      i_host_serial_model.ser_read(2'(i), rd);
      check(16'(rd & ((i == 2) ? 8'hDF : 8'hFF)), 16'(model[i]));
    end
    par_write(REG_AUX, 8'h20);
    for (int i = 0; i < 5; i++)
    begin
      cond[i] = 1'h1;
      tick(4);
      check(16'(int_n), 16'h0000);
      par_read(REG_DETECT, rd);
      check(16'(rd & 8'hDF), 16'(cond));
      check(16'(int_n), 16'h0001);
    end
    par_write(REG_AUX, 8'h00);
    cond[0] = 1'h0;
    tick(4);
    check(16'(int_n), 16'h0001);
    for (int i = 0; i < 2; i++)
    begin
      par_write(REG_TONE, (i == 0) ? 8'h17 : 8'h07);
      par_write(REG_MAIN, 8'h02);
      tone_and_data_select_seen = 0;
      par_write(REG_MAIN, 8'h00);
      check(16'(tone_and_data_select_seen), 16'(1 - i));
    end
    half_period(d);
    check(16'(d), 16'(XTAL_HALF_CYC));
    par_write(REG_AUX, 8'h08);
    half_period(d);
    check(16'(d), 16'(BAUD_HALF_CYC));
    reset_pin = 1'h1;
    tick(4);
    reset_pin = 1'h0;
    tick(4);
    check({main_control, aux_control | tone_and_data_select}, 16'h0000);
    half_period(d);
    check(16'(d), 16'(XTAL_HALF_CYC));
    cond[3] = 1'h0;
    tick(50);
    check(16'(recv_bit_clock), 16'h0000);
    demod_bit_valid = 1'h1;
    demod_bit = 1'($urandom);
    repeat (8)
    begin
      d = int'(demod_bit_ready === 1'h1);
      tick(1);
      if (d == 1)
      begin
        q.push_back(int'(demod_bit));
        demod_bit = 1'($urandom);
      end
    end
    demod_bit_valid = 1'h0;
    check(16'(q.size()), 16'h0002);
    cond[3] = 1'h1;
    repeat (2)
    begin
      wait_level(1'h1);
      wait_level(1'h0);
      wait_level(1'h1);
      check(16'(recv_data), 16'(q.pop_front()));
    end
    check(16'(demod_bit_ready), 16'h0001);
    // Power-down mode after the reset pin: transmit clock free-runs internally
    for (int w = 0; w < 100 && xmit_bit_strobe !== 1'h1; w++)
      tick(1);
    check(16'({xmit_bit_strobe, xmit_bit}), 16'({1'h1, xmit_data_in}));
    complete_run();
  end
endmodule
